// file: rtl/abz_core.sv
// Purpose: Detector indicators, buzzer, login levels and history browse
// Assumes: Detector states arrive as synchronous levels, one struct per channel
// Notes: Registers over Avalon-MM, one-cycle waitrequest on reads
`include "abz_defines.svh"
// Function
// - Light threshold indicators per detector
// - Catalytic overload locks, holds last value
// - Lock holds until explicit unlock
// - Non-catalytic overload lights arrow, keeps measuring
// - Buzzer excited by any gas threshold
// - Also excited by critical failures, unit failure and comm loss
// - Half-second sound and silence modulation
// - Mute silences; expiry resumes if still excited
// - New alarm, critical failure or comm loss ends mute
// - New alarm: higher threshold or other detector
// - Buzzer stops when excitation clears
// - Mute from keyboard, local or remote inputs
// - Gas mute one to ninety minutes
// - Failure mute 1-168 hours or permanent
// - Setting to never activate buzzer
// - Levels 0-2, start 0, password gated
// - Higher option first prompts for password
// - Four digit entry, one digit shown
// - Logout or one idle minute returns level 0
// - Three failures block login five minutes
// - History shows events, measurement off
// - Skip empty channels; clear needs confirm
module abz_core import abz_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire abz_det_s [7:0] det,
    input wire logic [15:0] value_in [8],
    input wire logic [3:0] discrete_input,
    input wire logic [3:0] remote_discrete_input,
    input wire logic unlock_ext,
    output logic [7:0] led_w1,
    output logic [7:0] led_w2,
    output logic [7:0] led_alarm,
    output logic [7:0] led_arrow,
    output logic [7:0] led_meas,
    output logic [7:0] led_fail,
    output logic [7:0] sensor_off,
    output logic [15:0] held_value [8],
    output logic buzzer,
    output logic [1:0] auth_level,
    output logic [3:0] pw_shown_digit,
    output logic [1:0] pw_digit_pos,
    output logic pw_prompt,
    output logic [2:0] lock_min_left
);
    // ****************************************
    // Timebase
    // ****************************************
    abz_tick_if tk ();
    abz_tick u_tick (.clk(clk), .nrst(nrst), .tk(tk));

    function automatic logic [1:0] lvl_of(input abz_det_s d);
        lvl_of = d.alarm ? 2'd3 : d.w2 ? 2'd2 : d.w1 ? 2'd1 : 2'd0;
    endfunction

    // ****************************************
    // Register bus
    // ****************************************
    logic [2:0] ctrl_reg;
    logic [6:0] almute_reg;
    logic [7:0] flmute_reg;
    logic [15:0] pw1_reg;
    logic [15:0] pw2_reg;
    logic rd_pend_reg;
    logic [31:0] rdata_reg;
    wire logic wr_ctrl = avs_write && avs_address == `ABZ_OFF_CTRL && avs_byteenable[0];
    wire logic wr_alm = avs_write && avs_address == `ABZ_OFF_ALMUTE && avs_byteenable[0];
    wire logic wr_flm = avs_write && avs_address == `ABZ_OFF_FLMUTE && avs_byteenable[0];
    wire logic wr_key = avs_write && avs_address == `ABZ_OFF_KEY && avs_byteenable[0];
    wire logic wr_pw = avs_write && avs_address == `ABZ_OFF_PWSET && avs_byteenable == 4'hf;
    wire logic [3:0] key_cmd = wr_key ? avs_writedata[3:0] : `ABZ_KEY_NOP;
    wire logic [3:0] key_dig = avs_writedata[7:4];
    wire logic [6:0] alm_clip = (avs_writedata[6:0] == 7'h0) ? 7'd1 :
                                (avs_writedata[6:0] > 7'd90) ? 7'd90 : avs_writedata[6:0];
    wire logic [7:0] flm_clip = (avs_writedata[7:0] == 8'h0) ? 8'd1 :
                                (avs_writedata[7:0] > 8'd168 && avs_writedata[7:0] != `ABZ_PERM_MUTE) ?
                                8'd168 : avs_writedata[7:0];
    assign avs_waitrequest = avs_read && !rd_pend_reg;
    assign avs_readdata = rdata_reg;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_reg <= 3'h0;
            almute_reg <= `ABZ_ALMUTE_RST;
            flmute_reg <= `ABZ_FLMUTE_RST;
            pw1_reg <= `ABZ_PW1_RST;
            pw2_reg <= `ABZ_PW2_RST;
        end else begin
            if (wr_ctrl) ctrl_reg <= avs_writedata[2:0];
            if (wr_alm) almute_reg <= alm_clip;
            if (wr_flm) flmute_reg <= flm_clip;
            if (wr_pw) begin
                pw1_reg <= avs_writedata[15:0];
                pw2_reg <= avs_writedata[31:16];
            end
        end
    end

    // ****************************************
    // Detector indicators and lock
    // ****************************************
    logic [7:0] locked_reg;
    logic [15:0] held_reg [8];
    logic [2:0] hist_ch_reg, sc_reg;
    logic [4:0] hist_data;
    logic [7:0] hist_ne;
    logic [7:0] w1_v, w2_v, al_v, ovc, ovn, cf_v, nf_v, cl_v;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            w1_v[i] = det[i].w1 | det[i].w2 | det[i].alarm;
            w2_v[i] = det[i].w2 | det[i].alarm;
            al_v[i] = det[i].alarm;
            ovc[i] = det[i].ovld & det[i].catalytic;
            ovn[i] = det[i].ovld & ~det[i].catalytic;
            cf_v[i] = det[i].crit_fail;
            nf_v[i] = det[i].noncrit_fail;
            cl_v[i] = det[i].comm_lost;
        end
    end
    wire logic unlock_cmd = (key_cmd == `ABZ_KEY_UNLOCK) && auth_level != 2'd0;
    wire logic hist_on = ctrl_reg[`ABZ_CTRL_HISTMODE];
    always_ff @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            if (!nrst) begin
                locked_reg[i] <= 1'b0;
                held_reg[i] <= 16'h0;
            end else if (ovc[i] && !locked_reg[i]) begin
                locked_reg[i] <= 1'b1;
            end else if (locked_reg[i] && ((unlock_cmd && hist_ch_reg == 3'(i)) || unlock_ext)) begin
                locked_reg[i] <= 1'b0;
            end
            if (nrst && !locked_reg[i]) held_reg[i] <= value_in[i];
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            led_w1 <= 8'h0;
            led_w2 <= 8'h0;
            led_alarm <= 8'h0;
            led_arrow <= 8'h0;
            led_meas <= 8'h0;
            led_fail <= 8'h0;
        end else if (hist_on) begin
            led_w1 <= 8'h0;
            led_w2 <= 8'h0;
            led_alarm <= 8'h0;
            led_arrow <= 8'h0;
            led_meas <= 8'h0;
            led_fail <= 8'h0;
            led_w1[hist_ch_reg] <= hist_data[0];
            led_w2[hist_ch_reg] <= hist_data[1];
            led_alarm[hist_ch_reg] <= hist_data[2];
            led_fail[hist_ch_reg] <= hist_data[3] | (hist_data[4] & tk.phase);
        end else begin
            led_w1 <= w1_v;
            led_w2 <= w2_v;
            led_alarm <= al_v;
            led_arrow <= ovn | (locked_reg & {8{tk.phase}});
            led_meas <= ~locked_reg & ~cf_v & ~cl_v;
            led_fail <= cf_v | (nf_v & {8{tk.phase}});
        end
    end
    assign sensor_off = locked_reg;
    assign held_value = held_reg;

    // ****************************************
    // Buzzer
    // ****************************************
    logic [1:0] prev_lvl_reg [8];
    logic [7:0] prev_fail_reg;
    logic gmute_reg, fmute_reg, fperm_reg;
    logic [12:0] gsec_reg;
    logic [19:0] fsec_reg;
    logic [7:0] new_gas;
    wire logic [7:0] fail_v = cf_v | cl_v;
    always_comb begin
        for (int i = 0; i < 8; i++) new_gas[i] = lvl_of(det[i]) > prev_lvl_reg[i];
    end
    wire logic gas_exc = |w1_v;
    wire logic fail_exc = (|fail_v) | ctrl_reg[`ABZ_CTRL_CUFAIL];
    wire logic new_fail = |(fail_v & ~prev_fail_reg);
    wire logic mute_req = (key_cmd == `ABZ_KEY_MUTE) || (|discrete_input) || (|remote_discrete_input);
    always_ff @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            if (!nrst) prev_lvl_reg[i] <= 2'd0;
            else prev_lvl_reg[i] <= lvl_of(det[i]);
        end
        if (!nrst) prev_fail_reg <= 8'h0;
        else prev_fail_reg <= fail_v;
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            gmute_reg <= 1'b0;
            fmute_reg <= 1'b0;
            fperm_reg <= 1'b0;
            gsec_reg <= 13'h0;
            fsec_reg <= 20'h0;
        end else begin
            if (|new_gas || new_fail) begin
                gmute_reg <= 1'b0;
                fmute_reg <= 1'b0;
                fperm_reg <= 1'b0;
            end else if (mute_req) begin
                gmute_reg <= 1'b1;
                gsec_reg <= 13'(almute_reg * 60);
                fmute_reg <= 1'b1;
                fperm_reg <= (flmute_reg == `ABZ_PERM_MUTE);
                fsec_reg <= 20'(flmute_reg * 3600);
            end else if (tk.sec) begin
                if (gmute_reg) begin
                    if (gsec_reg <= 13'd1) gmute_reg <= 1'b0;
                    gsec_reg <= gsec_reg - 13'd1;
                end
                if (fmute_reg && !fperm_reg) begin
                    if (fsec_reg <= 20'd1) fmute_reg <= 1'b0;
                    fsec_reg <= fsec_reg - 20'd1;
                end
            end
        end
    end
    wire logic sound_gas = gas_exc && !gmute_reg;
    wire logic sound_fail = fail_exc && !fmute_reg;
    wire logic buz_on = (sound_gas || sound_fail) && !ctrl_reg[`ABZ_CTRL_NEVER];
    always_ff @(posedge clk) begin
        if (!nrst) buzzer <= 1'b0;
        else buzzer <= buz_on && !tk.phase;
    end

    // ****************************************
    // Login
    // ****************************************
    abz_auth_e ast_reg;
    abz_level_e lvl_reg, tgt_reg;
    logic [15:0] pw_reg;
    logic [1:0] pos_reg, fails_reg;
    logic [5:0] idle_reg;
    logic [8:0] lock_reg;
    wire logic [15:0] pw_want = (tgt_reg == ABZ_LV2) ? pw2_reg : pw1_reg;
    wire logic [3:0] cur_dig = pw_reg[pos_reg*4 +: 4];
    wire logic req_hi = (key_cmd == `ABZ_KEY_REQ1) || (key_cmd == `ABZ_KEY_REQ2);
    wire abz_level_e req_lvl = (key_cmd == `ABZ_KEY_REQ2) ? ABZ_LV2 : ABZ_LV1;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ast_reg <= ABZ_AS_IDLE;
            lvl_reg <= ABZ_LV0;
            tgt_reg <= ABZ_LV0;
            pw_reg <= 16'h0;
            pos_reg <= 2'd0;
            fails_reg <= 2'd0;
            idle_reg <= 6'h0;
            lock_reg <= 9'h0;
        end else begin
            if (wr_key) idle_reg <= 6'h0;
            else if (tk.sec && idle_reg != 6'(`ABZ_IDLE_S)) idle_reg <= idle_reg + 6'h1;
            if (tk.sec && lock_reg != 9'h0) lock_reg <= lock_reg - 9'h1;
            if (key_cmd == `ABZ_KEY_LOGOUT || (!wr_key && tk.sec && idle_reg == 6'(`ABZ_IDLE_S - 1))) begin
                lvl_reg <= ABZ_LV0;
                ast_reg <= (ast_reg == ABZ_AS_LOCKED) ? ABZ_AS_LOCKED : ABZ_AS_IDLE;
            end else begin
                unique case (ast_reg)
                    ABZ_AS_IDLE: begin
                        if (req_hi && req_lvl > lvl_reg) begin
                            ast_reg <= ABZ_AS_PROMPT;
                            tgt_reg <= req_lvl;
                            pw_reg <= 16'h0;
                            pos_reg <= 2'd0;
                        end
                    end
                    ABZ_AS_PROMPT: begin
                        if (key_cmd == `ABZ_KEY_DIGUP) begin
                            pw_reg[pos_reg*4 +: 4] <= (key_dig > 4'd9) ? 4'd0 : key_dig;
                        end else if (key_cmd == `ABZ_KEY_DIGNXT) begin
                            pos_reg <= pos_reg + 2'd1;
                        end else if (key_cmd == `ABZ_KEY_ENTER) begin
                            if (pw_reg == pw_want) begin
                                lvl_reg <= tgt_reg;
                                fails_reg <= 2'd0;
                                ast_reg <= ABZ_AS_IDLE;
                            end else if (fails_reg == `ABZ_MAX_FAILS - 2'd1) begin
                                fails_reg <= 2'd0;
                                lock_reg <= 9'(`ABZ_LOCKOUT_S);
                                ast_reg <= ABZ_AS_LOCKED;
                            end else begin
                                fails_reg <= fails_reg + 2'd1;
                                ast_reg <= ABZ_AS_IDLE;
                            end
                        end
                    end
                    ABZ_AS_LOCKED: begin
                        if (lock_reg == 9'h0) ast_reg <= ABZ_AS_IDLE;
                    end
                endcase
            end
        end
    end
    assign auth_level = lvl_reg;
    assign pw_prompt = (ast_reg == ABZ_AS_PROMPT);
    assign pw_shown_digit = cur_dig;
    assign pw_digit_pos = pos_reg;
    assign lock_min_left = 3'((lock_reg + 9'd59) / 9'd60);

    // ****************************************
    // History
    // ****************************************
    logic clr_arm_reg;
    wire logic clr_go = clr_arm_reg && key_cmd == `ABZ_KEY_HCONF;
    logic [2:0] nxt_ch;
    always_comb begin
        nxt_ch = hist_ch_reg;
        for (int k = 7; k >= 1; k--) begin
            if (hist_ne[3'(hist_ch_reg + 3'(k))]) nxt_ch = 3'(hist_ch_reg + 3'(k));
        end
    end
    always_ff @(posedge clk) begin
        sc_reg <= nrst ? sc_reg + 3'h1 : 3'h0;
        if (!nrst) begin
            hist_ch_reg <= 3'h0;
            clr_arm_reg <= 1'b0;
        end else begin
            if (key_cmd == `ABZ_KEY_HNEXT) hist_ch_reg <= nxt_ch;
            if (key_cmd == `ABZ_KEY_HCLR) clr_arm_reg <= 1'b1;
            else if (wr_key) clr_arm_reg <= 1'b0;
        end
    end
    abz_hist_mem u_hist (
        .clk(clk),
        .nrst(nrst),
        .clr(clr_go),
        .set_mask(8'h1 << sc_reg),
        .set_bits({nf_v[sc_reg], cf_v[sc_reg], al_v[sc_reg], w2_v[sc_reg], w1_v[sc_reg]}),
        .rd_ch(hist_ch_reg),
        .rd_data(hist_data),
        .nonempty(hist_ne)
    );

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_pend_reg <= 1'b0;
            rdata_reg <= 32'h0;
        end else begin
            rd_pend_reg <= avs_read && !rd_pend_reg;
            unique case (avs_address)
                `ABZ_OFF_CTRL: rdata_reg <= {29'h0, ctrl_reg};
                `ABZ_OFF_ALMUTE: rdata_reg <= {25'h0, almute_reg};
                `ABZ_OFF_FLMUTE: rdata_reg <= {24'h0, flmute_reg};
                `ABZ_OFF_STATUS: rdata_reg <= {16'h0, lock_reg[7:0], fails_reg, buzzer, fmute_reg,
                                               gmute_reg, pw_prompt, lvl_reg};
                `ABZ_OFF_HIST: rdata_reg <= {16'h0, hist_ne, clr_arm_reg, hist_ch_reg, hist_data[3:0]};
                `ABZ_OFF_LEDS: rdata_reg <= {8'h0, locked_reg, led_alarm, led_w1};
                default: rdata_reg <= 32'h0;
            endcase
        end
    end
endmodule // abz_core

// file: rtl/abz_defines.svh
// Purpose: Shared constants of the alarm buzzer and access block
// Assumes: 50 MHz clock, one-second timebase derived inside
// Notes: Offsets are byte addresses on the Avalon-MM slave
`ifndef ABZ_DEFINES_SVH
`define ABZ_DEFINES_SVH

`define ABZ_NCH 8
// Register byte offsets
`define ABZ_OFF_CTRL 6'h00
`define ABZ_OFF_ALMUTE 6'h04
`define ABZ_OFF_FLMUTE 6'h08
`define ABZ_OFF_KEY 6'h0c
`define ABZ_OFF_PWSET 6'h10
`define ABZ_OFF_STATUS 6'h14
`define ABZ_OFF_HIST 6'h18
`define ABZ_OFF_LEDS 6'h1c
// CTRL fields
`define ABZ_CTRL_NEVER 0
`define ABZ_CTRL_CUFAIL 1
`define ABZ_CTRL_HISTMODE 2
// KEY command codes (write data [3:0]), digit in [7:4]
`define ABZ_KEY_MUTE 4'h1
`define ABZ_KEY_REQ1 4'h2
`define ABZ_KEY_REQ2 4'h3
`define ABZ_KEY_DIGUP 4'h4
`define ABZ_KEY_DIGNXT 4'h5
`define ABZ_KEY_ENTER 4'h6
`define ABZ_KEY_LOGOUT 4'h7
`define ABZ_KEY_HNEXT 4'h8
`define ABZ_KEY_HCLR 4'h9
`define ABZ_KEY_HCONF 4'ha
`define ABZ_KEY_UNLOCK 4'hb
`define ABZ_KEY_NOP 4'h0
// Reset values
`define ABZ_ALMUTE_RST 7'd5
`define ABZ_FLMUTE_RST 8'd24
`define ABZ_PW1_RST 16'h1111
`define ABZ_PW2_RST 16'h2222
// Timing
`define ABZ_CLK_HZ 50000000
`define ABZ_HALF_S_MS 500
`define ABZ_HALF_S_CYC (`ABZ_CLK_HZ / 1000 * `ABZ_HALF_S_MS)
`define ABZ_IDLE_S 60
`define ABZ_LOCKOUT_S 300
`define ABZ_MAX_FAILS 2'd3
`define ABZ_PERM_MUTE 8'hff
`endif

// file: rtl/abz_pkg.sv
// Purpose: Types of the alarm buzzer and access block
// Assumes: Included header gives the widths
// Notes: None
`include "abz_defines.svh"
package abz_pkg;
    typedef enum logic [1:0] {ABZ_LV0, ABZ_LV1, ABZ_LV2} abz_level_e;
    typedef enum {ABZ_AS_IDLE, ABZ_AS_PROMPT, ABZ_AS_LOCKED} abz_auth_e;
    typedef struct packed {
        logic w1;
        logic w2;
        logic alarm;
        logic ovld;
        logic catalytic;
        logic crit_fail;
        logic noncrit_fail;
        logic comm_lost;
    } abz_det_s;
endpackage

// file: rtl/abz_tick_if.sv
// Purpose: Timebase carrier between top and tick generator
// Assumes: One clock domain
// Notes: Pulses last one cycle
interface abz_tick_if;
    logic half_s;
    logic sec;
    logic phase;
    modport gen (output half_s, output sec, output phase);
    modport use_ (input half_s, input sec, input phase);
endinterface

// file: rtl/abz_tick.sv
// Purpose: Half-second and one-second tick generator
// Assumes: 50 MHz clock
// Notes: Phase toggles every half second
module abz_tick (
    input wire logic clk,
    input wire logic nrst,
    abz_tick_if.gen tk
);
    logic [24:0] cnt_reg;
    logic ph_reg;
    wire logic wrap = (cnt_reg == 25'(`ABZ_HALF_S_CYC - 1));
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_reg <= 25'h0;
            ph_reg <= 1'b0;
        end else begin
            cnt_reg <= wrap ? 25'h0 : cnt_reg + 25'h1;
            if (wrap) ph_reg <= ~ph_reg;
        end
    end
    assign tk.half_s = wrap;
    assign tk.sec = wrap & ph_reg;
    assign tk.phase = ph_reg;
endmodule // abz_tick

// file: rtl/abz_hist_mem.sv
// Purpose: Stored event memory, one word per channel
// Assumes: Single write port, registered read
// Notes: Clear wipes all channels
module abz_hist_mem (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clr,
    input wire logic [7:0] set_mask,
    input wire logic [4:0] set_bits,
    input wire logic [2:0] rd_ch,
    output logic [4:0] rd_data,
    output logic [7:0] nonempty
);
    logic [4:0] mem_reg [8];
    always_ff @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            if (!nrst || (clr && !set_mask[i])) mem_reg[i] <= 5'h0;
            else if (set_mask[i]) mem_reg[i] <= (clr ? 5'h0 : mem_reg[i]) | set_bits;
        end
        if (!nrst) rd_data <= 5'h0;
        else rd_data <= mem_reg[rd_ch];
    end
    always_comb begin
        for (int i = 0; i < 8; i++) nonempty[i] = |mem_reg[i];
    end
endmodule // abz_hist_mem

// file: test/abz_core_checker.sv
// Purpose: Port assertions for abz_core
// Assumes: One clock, sync active-low reset
// Notes: Unit fail bit mirrored from bus writes
module abz_core_checker import abz_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [5:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire abz_det_s [7:0] det,
    input wire logic unlock_ext,
    input wire logic [7:0] led_w1,
    input wire logic [7:0] led_alarm,
    input wire logic [7:0] led_arrow,
    input wire logic [7:0] led_meas,
    input wire logic [7:0] sensor_off,
    input wire logic [15:0] held_value [8],
    input wire logic buzzer,
    input wire logic [1:0] auth_level,
    input wire logic pw_prompt,
    input wire logic [2:0] lock_min_left
);
    // ****************
    // Helpers and checks
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic cu_reg;
    logic exc;
    logic key_wr;
    logic enter_wr;
    assign key_wr = avs_write && avs_address == 6'h0c;
    assign enter_wr = key_wr && avs_writedata[3:0] == 4'h6;
    always_ff @(posedge clk) begin
        if (!nrst) cu_reg <= 1'b0;
        else if (avs_write && avs_address == 6'h00) cu_reg <= avs_writedata[1];
    end
    always_comb begin
        exc = cu_reg;
        for (int i = 0; i < 8; i++) exc = exc | (|(det[i] & 8'he5));
    end
    for (genvar i = 0; i < 8; i++) begin : g_ch
        AST_W1: assert property (det[i].w1 |-> ##[1:2] led_w1[i]) else $error("w1 led");
        AST_ALM: assert property (det[i].alarm |-> ##[1:2] led_alarm[i]) else $error("alarm led");
        AST_ARROW: assert property (det[i].ovld && !det[i].catalytic && !det[i].crit_fail && !det[i].comm_lost
            |-> ##[1:2] led_arrow[i] && led_meas[i]) else $error("arrow led");
        AST_LOCK: assert property (det[i].ovld && det[i].catalytic |-> ##[1:2] sensor_off[i]) else
            $error("no lock");
        AST_HOLD: assert property (sensor_off[i] && !unlock_ext && !key_wr |=> sensor_off[i]) else
            $error("lock lost");
        AST_HELD: assert property (sensor_off[i] [*3] |-> $stable(held_value[i])) else $error("held moved");
    end
    AST_BUZ_OFF: assert property (!exc [*2] |-> !buzzer) else $error("buzzer idle on");
    AST_AUTH_UP: assert property (auth_level > $past(auth_level) |-> $past(enter_wr)) else $error("level rose");
    AST_LOGOUT: assert property (key_wr && avs_writedata[3:0] == 4'h7 |=> auth_level == 2'h0) else
        $error("logout");
    AST_PROMPT: assert property (key_wr && avs_writedata[3:0] == 4'h2 && auth_level == 2'h0 && lock_min_left == 3'h0
        |=> pw_prompt) else $error("no prompt");
    AST_LOCK_MAX: assert property (lock_min_left <= 3'h5) else $error("lockout minutes");
endmodule // abz_core_checker

bind abz_core abz_core_checker u_chk (.*);

// file: test/abz_det_model.sv
// Purpose: Connected detectors, one state word per channel
// Assumes: Bench loads one channel at a time
// Notes: Cleared by reset
module abz_det_model import abz_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ld,
    input wire logic [2:0] ch,
    input wire logic [7:0] st,
    input wire logic [15:0] val,
    output abz_det_s [7:0] det,
    output logic [15:0] value_in [8]
);
    // ****************
    // Channel states
    // ****************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            det <= '0;
            for (int i = 0; i < 8; i++) value_in[i] <= 16'h0;
        end else if (ld) begin
            det[ch] <= abz_det_s'(st);
            value_in[ch] <= val;
        end
    end
endmodule // abz_det_model

// file: test/tb_alarm_buzzer_and_access_control.sv
// Purpose: Self-checking bench of abz_core
// Assumes: Detector model drives det and value_in
// Notes: Half-second and minute timers too long to run out
module tb_alarm_buzzer_and_access_control import abz_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic nrst = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    abz_det_s [7:0] det;
    logic [15:0] value_in [8];
    logic [3:0] discrete_input = 4'h0;
    logic [3:0] remote_discrete_input = 4'h0;
    logic unlock_ext = 1'b0;
    logic [7:0] led_w1, led_w2, led_alarm, led_arrow, led_meas, led_fail, sensor_off;
    logic [15:0] held_value [8];
    logic buzzer, pw_prompt, bz;
    logic [1:0] auth_level, pw_digit_pos;
    logic [3:0] pw_shown_digit;
    logic [2:0] lock_min_left;
    logic ld = 1'b0;
    logic [2:0] ch = 3'h0;
    logic [7:0] st = 8'h00;
    logic [15:0] val = 16'h0;
    logic [31:0] q;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;

    abz_core dut (.*);
    abz_det_model u_det (.*);

    // ****************
    // Tasks
    // ****************
    task automatic wrap_up;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic key(input logic [7:0] k);
        bus(1'b1, 6'h0c, 32'(k), q);
    endtask
    task automatic put(input logic [2:0] c, input logic [7:0] s, input logic [15:0] v);
        ld <= 1'b1;
        ch <= c;
        st <= s;
        val <= v;
        @(posedge clk);
        ld <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic quiet(input int n, output logic b);
        b = 1'b0;
        @(posedge clk);
        repeat (n) begin
            @(negedge clk);
            b = b | buzzer;
        end
        @(posedge clk);
    endtask

    // ****************
    // Clock, timeout, tests
    // ****************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        bus(1'b0, 6'h04, 32'h0, q);
        chk("almute", 32'd5, q);
        bus(1'b0, 6'h08, 32'h0, q);
        chk("flmute", 32'd24, q);
        bus(1'b1, 6'h04, 32'd90, q);
        bus(1'b0, 6'h04, 32'h0, q);
        chk("almute", 32'd90, q);
        bus(1'b1, 6'h08, 32'hff, q);
        bus(1'b0, 6'h08, 32'h0, q);
        chk("flmute", 32'hff, q);
        bus(1'b0, 6'h3c, 32'h0, q);
        chk("unmapped", 32'h0, q);
        $display("done regs");
        put(3'd2, 8'h80, 16'h10);
        chk("w1", 32'h04, 32'(led_w1));
        put(3'd2, 8'he0, 16'h30);
        chk("alarm", 32'h04, 32'(led_alarm));
        put(3'd2, 8'h00, 16'h0);
        chk("buzzer", 32'h0, 32'(buzzer));
        put(3'd4, 8'hf0, 16'h99);
        chk("arrow", 32'h10, 32'(led_arrow));
        chk("meas", 32'h1, 32'(led_meas[4]));
        put(3'd4, 8'h00, 16'h0);
        $display("done thresholds");
        put(3'd5, 8'hf8, 16'h1234);
        chk("lock", 32'h20, 32'(sensor_off));
        chk("meas", 32'h0, 32'(led_meas[5]));
        put(3'd5, 8'h00, 16'h0042);
        chk("lock", 32'h20, 32'(sensor_off));
        chk("held", 32'h1234, 32'(held_value[5]));
        unlock_ext <= 1'b1;
        @(posedge clk);
        unlock_ext <= 1'b0;
        repeat (3) @(posedge clk);
        chk("unlock", 32'h0, 32'(sensor_off));
        $display("done lock");
        key(8'h02);
        chk("prompt", 32'h1, 32'(pw_prompt));
        for (int i = 0; i < 4; i++) begin
            key(8'h14);
            chk("digit", 32'h1, 32'(pw_shown_digit));
            chk("pos", 32'(i), 32'(pw_digit_pos));
            key(8'h05);
        end
        key(8'h06);
        chk("level", 32'h1, 32'(auth_level));
        key(8'h07);
        chk("level", 32'h0, 32'(auth_level));
        repeat (3) begin
            key(8'h03);
            key(8'h06);
        end
        chk("level", 32'h0, 32'(auth_level));
        key(8'h02);
        chk("lockout", 32'h5, 32'(lock_min_left));
        $display("done login");
        put(3'd1, 8'h80, 16'h0);
        chk("buzzer", 32'h1, 32'(buzzer));
        key(8'h01);
        quiet(200, bz);
        chk("mute", 32'h0, 32'(bz));
        for (int s = 0; s < 2; s++) begin
            put(3'(3 + s), 8'h80, 16'h0);
            chk("resume", 32'h1, 32'(buzzer));
            if (s == 0) discrete_input <= 4'h1;
            else remote_discrete_input <= 4'h8;
            @(posedge clk);
            discrete_input <= 4'h0;
            remote_discrete_input <= 4'h0;
            quiet(100, bz);
            chk("input mute", 32'h0, 32'(bz));
        end
        bus(1'b1, 6'h00, 32'h3, q);
        put(3'd6, 8'he0, 16'h0);
        quiet(100, bz);
        chk("never", 32'h0, 32'(bz));
        bus(1'b1, 6'h00, 32'h0, q);
        for (int c = 0; c < 8; c++) put(3'(c), 8'h00, 16'h0);
        chk("buzzer", 32'h0, 32'(buzzer));
        $display("done buzzer");
        wrap_up();
    end
endmodule // tb_alarm_buzzer_and_access_control
